// ===== hbp_defines.svh
`ifndef HBP_DEFINES_SVH
`define HBP_DEFINES_SVH

`define HBP_CLK_PERIOD_NS   50
`define HBP_ABORT_TIME_NS   750000
`define HBP_ABORT_CYCLES    (`HBP_ABORT_TIME_NS / `HBP_CLK_PERIOD_NS)
`define HBP_SEL_DATA        1'b0
`define HBP_SEL_FLAGS       1'b1
`define HBP_FLAG_WRITE_BIT  0
`define HBP_FLAG_REPLY_BIT  1
`define HBP_FETCH_CMD       8'h70
`define HBP_SET_ADDR_CMD    8'h7C
`define HBP_SUCCESS_TERM    8'h00
`define HBP_MEAS_BYTES      3'h3
`define HBP_LAST_IDX        3'h4
`define HBP_ADDR_DEFAULT    8'hC0
`define HBP_ZERO_BYTE       8'h00

`endif

// ===== hbp_host.sv
`timescale 1ns/1ps
`default_nettype none
module hbp_host (
  // clock
  input  wire logic       i_clk,
  // bus pins
  input  wire logic [7:0] i_sd,
  output logic      [9:0] o_sa,
  output logic            o_ior_n,
  output logic            o_iow_n,
  output logic      [7:0] o_sd
);
  initial begin
    o_sa = 10'h000;
    o_ior_n = 1'b1;
    o_iow_n = 1'b1;
    o_sd = 8'h00;
  end
  // address set up 3 clocks, strobe 6 low, 5 idle after
  task automatic cyc(input logic [9:0] a, input logic rd, input logic [7:0] wd, output logic [7:0] q);
    @(negedge i_clk);
    o_sa = a;
    o_sd = wd;
    repeat (3) @(negedge i_clk);
    if (rd) o_ior_n = 1'b0;
    else o_iow_n = 1'b0;
    repeat (6) @(negedge i_clk);
    q = i_sd;
    o_ior_n = 1'b1;
    o_iow_n = 1'b1;
    repeat (5) @(negedge i_clk);
    o_sd = ~wd; // stale data never looks valid
  endtask
  // poll flags until bit b equals v; bounded wait stands in for two seconds
  task automatic poll(input logic [7:0] ba, input int b, input logic v, output logic [7:0] f);
    // start opposite to the wanted level so at least one read is made
    f = {8{~v}};
    for (int n = 0; n < 40 && f[b] !== v; n++) begin
      cyc({ba, 2'b01}, 1'b1, 8'h00, f);
    end
  endtask
endmodule // hbp_host
`default_nettype wire

// ===== hbp_nvm.sv
`timescale 1ns/1ps
`default_nettype none
`include "hbp_defines.svh"
module hbp_nvm #(
  parameter logic [7:0] INIT = `HBP_ADDR_DEFAULT
) (
  // clock
  input  wire logic       i_clk,
  // write port
  input  wire logic       i_we,
  input  wire logic [7:0] i_wdata,
  // registered read
  output logic      [7:0] o_rdata
);
  // not reset: contents survive any reset, like the on-board store
  logic [7:0] cell_r = INIT;

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      cell_r <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    o_rdata <= cell_r;
  end
endmodule // hbp_nvm
`default_nettype wire

// ===== hbp_pkg.sv
`default_nettype none
package hbp_pkg;
  typedef enum logic [2:0] {
    HBP_BOOT,
    HBP_IDLE,
    HBP_DECODE,
    HBP_SEND,
    HBP_WAIT_ARG
  } hbp_seq_e;
  typedef logic [7:0] hbp_byte_t;
endpackage
`default_nettype wire

// ===== hbp_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "hbp_defines.svh"
module hbp_sva #(
  parameter int ABORT_CYCLES = `HBP_ABORT_CYCLES
) (
  // clock and reset
  input wire logic       I_REF_CLK,
  input wire logic       I_SRST,
  // bus pins
  input wire logic [9:0] I_SA,
  input wire logic       I_IOR_N,
  input wire logic       I_IOW_N,
  input wire logic [7:0] O_SD,
  input wire logic       O_SD_OE,
  // status
  input wire logic [7:0] O_BUS_ADDR,
  input wire logic       O_ABORT
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_SRST);
  logic [15:0] idle_r;
  wire         dsel = !I_SA[0] && !(I_IOR_N && I_IOW_N);
  // cycles since the last data port strobe
  always_ff @(posedge I_REF_CLK) begin
    idle_r <= (I_SRST || dsel) ? 16'h0000 : idle_r + 16'h0001;
  end
  property p_hit; $rose(O_SD_OE) |-> !$past(I_IOR_N, 2) && $past(I_SA[9:2], 2) == O_BUS_ADDR; endproperty
  a_hit: assert property (p_hit) else $error("drive without selected read");
  property p_miss; $fell(I_IOR_N) && I_SA[9:2] != O_BUS_ADDR |-> ##2 !O_SD_OE [*3]; endproperty
  a_miss: assert property (p_miss) else $error("drive on foreign address");
  property p_rise; $fell(I_IOR_N) && I_SA[9:2] == O_BUS_ADDR |-> ##[2:4] O_SD_OE; endproperty
  a_rise: assert property (p_rise) else $error("read not answered");
  property p_fall; $rose(I_IOR_N) |-> ##[2:5] !O_SD_OE; endproperty
  a_fall: assert property (p_fall) else $error("drive held after read");
  property p_hold; $fell(O_SD_OE) |-> $past(I_IOR_N, 2); endproperty
  a_hold: assert property (p_hold) else $error("drive dropped early");
  property p_flags; O_SD_OE && I_SA[0] |-> O_SD[7:2] == 6'h00; endproperty
  a_flags: assert property (p_flags) else $error("flag upper bits set");
  property p_stand; O_SD_OE && $past(O_SD_OE) && !I_IOR_N && !I_SA[0] |-> $stable(O_SD); endproperty
  a_stand: assert property (p_stand) else $error("reply byte moved mid read");
  property p_abort; O_ABORT |-> idle_r >= ABORT_CYCLES; endproperty
  a_abort: assert property (p_abort) else $error("abort too early");
  property p_pulse; O_ABORT |=> !O_ABORT; endproperty
  a_pulse: assert property (p_pulse) else $error("abort not a pulse");
  c_abort: cover property (O_ABORT);
  c_data: cover property ($rose(O_SD_OE) && !I_SA[0]);
  c_move: cover property ($changed(O_BUS_ADDR) && O_BUS_ADDR == 8'h80);
endmodule // hbp_sva
bind hbp_top hbp_sva #(.ABORT_CYCLES(ABORT_CYCLES)) u_sva (.I_REF_CLK, .I_SRST, .I_SA, .I_IOR_N, .I_IOW_N,
  .O_SD, .O_SD_OE, .O_BUS_ADDR, .O_ABORT);
`default_nettype wire

// ===== hbp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module hbp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // levels
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_r <= '0;
      o_sync <= '0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule // hbp_sync
`default_nettype wire

// ===== hbp_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "hbp_defines.svh"
module hbp_top
  import hbp_pkg::*;
#(
  parameter int ABORT_CYCLES = `HBP_ABORT_CYCLES
) (
  // clock and reset
  input  wire logic       I_REF_CLK,
  input  wire logic       I_SRST,
  // bus pins
  input  wire logic [9:0] I_SA,
  input  wire logic       I_IOR_N,
  input  wire logic       I_IOW_N,
  input  wire logic [7:0] I_SD,
  output logic      [7:0] O_SD,
  output logic            O_SD_OE,
  // measurement source
  input  wire logic [23:0] I_MEAS_VALUE,
  output logic      [1:0]  O_MEAS_CHAN,
  // status
  output logic      [7:0] O_BUS_ADDR,
  output logic            O_ABORT
);
  logic [9:0]  sa_s;
  logic [7:0]  sd_s;
  logic [1:0]  strb_s;
  logic        ior_n_q_r;
  logic        iow_n_q_r;
  logic        rd_sel_r;
  logic        rd_port_r;
  logic        wr_sel_r;
  logic        wr_port_r;
  logic        ibf_r;
  logic        obf_r;
  hbp_byte_t   in_buf_r;
  hbp_byte_t   out_buf_r;
  hbp_byte_t   cmd_r;
  hbp_byte_t   addr_r;
  hbp_byte_t   nvm_q;
  logic        nvm_we;
  hbp_seq_e    seq_r;
  logic [2:0]  idx_r;
  logic [31:0] tmo_r;
  logic        take;
  logic        load;
  logic        abort;
  logic        ior_lead;
  logic        ior_trail;
  logic        iow_lead;
  logic        iow_trail;
  logic        host_data_wr;
  logic        host_data_rd_end;
  logic        hit;
  hbp_byte_t   flags_byte;

  function automatic logic addr_hit(input logic [9:0] sa, input logic [7:0] base);
    addr_hit = (sa[9:2] == base);
  endfunction

  function automatic hbp_byte_t reply_byte(input logic [2:0] idx, input logic [23:0] meas);
    case (idx)
      3'h0:    reply_byte = meas[7:0];
      3'h1:    reply_byte = meas[15:8];
      3'h2:    reply_byte = meas[23:16];
      default: reply_byte = `HBP_SUCCESS_TERM;
    endcase
  endfunction

  hbp_sync #(.W(10)) u_sa_sync (
    .i_clk   (I_REF_CLK),
    .i_rst   (I_SRST),
    .i_async (I_SA),
    .o_sync  (sa_s)
  );

  hbp_sync #(.W(8)) u_sd_sync (
    .i_clk   (I_REF_CLK),
    .i_rst   (I_SRST),
    .i_async (I_SD),
    .o_sync  (sd_s)
  );

  // strobes idle high
  hbp_sync #(.W(2)) u_strb_sync (
    .i_clk   (I_REF_CLK),
    .i_rst   (I_SRST),
    .i_async ({~I_IOR_N, ~I_IOW_N}),
    .o_sync  (strb_s)
  );

  hbp_nvm #(.INIT(`HBP_ADDR_DEFAULT)) u_nvm (
    .i_clk   (I_REF_CLK),
    .i_we    (nvm_we),
    .i_wdata (in_buf_r),
    .o_rdata (nvm_q)
  );

  // strobe edges from the synchronised copies only
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      ior_n_q_r <= 1'b1;
      iow_n_q_r <= 1'b1;
    end else begin
      ior_n_q_r <= ~strb_s[1];
      iow_n_q_r <= ~strb_s[0];
    end
  end

  assign ior_lead  = ior_n_q_r & strb_s[1];
  assign ior_trail = ~ior_n_q_r & ~strb_s[1];
  assign iow_lead  = iow_n_q_r & strb_s[0];
  assign iow_trail = ~iow_n_q_r & ~strb_s[0];
  // decoding waits for the boot load so a stale address never answers
  assign hit       = (seq_r != HBP_BOOT) && addr_hit(sa_s, addr_r);

  // cycle qualification latched at the leading edge
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      rd_sel_r  <= 1'b0;
      rd_port_r <= 1'b0;
      wr_sel_r  <= 1'b0;
      wr_port_r <= 1'b0;
    end else begin
      if (ior_lead) begin
        rd_sel_r  <= hit;
        rd_port_r <= sa_s[0];
      end else if (ior_trail) begin
        rd_sel_r <= 1'b0;
      end
      if (iow_lead) begin
        wr_sel_r  <= hit;
        wr_port_r <= sa_s[0];
      end else if (iow_trail) begin
        wr_sel_r <= 1'b0;
      end
    end
  end

  assign host_data_wr     = iow_trail & wr_sel_r & (wr_port_r == `HBP_SEL_DATA);
  assign host_data_rd_end = ior_trail & rd_sel_r & (rd_port_r == `HBP_SEL_DATA);

  // overwrite allowed: no guard against a pending byte
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      in_buf_r <= `HBP_ZERO_BYTE;
    end else if (host_data_wr) begin
      in_buf_r <= sd_s;
    end
  end

  // set wins over clear on both flags
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      ibf_r <= 1'b0;
    end else if (host_data_wr) begin
      ibf_r <= 1'b1;
    end else if (take || abort) begin
      ibf_r <= 1'b0;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      obf_r <= 1'b0;
    end else if (load) begin
      obf_r <= 1'b1;
    end else if (host_data_rd_end || abort) begin
      obf_r <= 1'b0;
    end
  end

  // flag byte from named bit positions; upper bits stay zero
  always_comb begin
    flags_byte                      = `HBP_ZERO_BYTE;
    flags_byte[`HBP_FLAG_WRITE_BIT] = ibf_r;
    flags_byte[`HBP_FLAG_REPLY_BIT] = obf_r;
  end

  // read data driven while the strobe is low; flag writes land nowhere
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      O_SD    <= `HBP_ZERO_BYTE;
      O_SD_OE <= 1'b0;
    end else begin
      O_SD_OE <= rd_sel_r & strb_s[1];
      if (rd_port_r == `HBP_SEL_DATA) begin
        O_SD <= out_buf_r;
      end else begin
        O_SD <= flags_byte;
      end
    end
  end

  // on-board sequencer
  assign take   = ((seq_r == HBP_IDLE) || (seq_r == HBP_WAIT_ARG)) && ibf_r;
  assign load   = (seq_r == HBP_SEND) && !obf_r && (idx_r != `HBP_LAST_IDX);
  assign abort  = ((seq_r == HBP_SEND) || (seq_r == HBP_WAIT_ARG)) &&
                  (tmo_r >= 32'(ABORT_CYCLES - 1));
  assign nvm_we = (seq_r == HBP_WAIT_ARG) && ibf_r;

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      seq_r       <= HBP_BOOT;
      cmd_r       <= `HBP_ZERO_BYTE;
      idx_r       <= 3'h0;
      addr_r      <= `HBP_ZERO_BYTE;
      O_MEAS_CHAN <= 2'h0;
    end else if (abort) begin
      seq_r <= HBP_IDLE;
    end else begin
      case (seq_r)
        HBP_BOOT: begin
          addr_r <= nvm_q;
          seq_r  <= HBP_IDLE;
        end
        HBP_IDLE: begin
          if (ibf_r) begin
            cmd_r <= in_buf_r;
            seq_r <= HBP_DECODE;
          end
        end
        HBP_DECODE: begin
          idx_r <= 3'h0;
          if (cmd_r[7:2] == 6'(`HBP_FETCH_CMD >> 2)) begin
            O_MEAS_CHAN <= cmd_r[1:0];
            seq_r       <= HBP_SEND;
          end else if (cmd_r == `HBP_SET_ADDR_CMD) begin
            seq_r <= HBP_WAIT_ARG;
          end else begin
            seq_r <= HBP_IDLE;
          end
        end
        HBP_SEND: begin
          if (!obf_r) begin
            if (idx_r == `HBP_LAST_IDX) begin
              seq_r <= HBP_IDLE;
            end else begin
              idx_r <= idx_r + 3'h1;
            end
          end
        end
        HBP_WAIT_ARG: begin
          if (ibf_r) begin
            addr_r <= in_buf_r;
            idx_r  <= `HBP_MEAS_BYTES;
            seq_r  <= HBP_SEND;
          end
        end
        default: seq_r <= HBP_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      out_buf_r <= `HBP_ZERO_BYTE;
    end else if (load) begin
      out_buf_r <= reply_byte(idx_r, I_MEAS_VALUE);
    end
  end

  // waiting time restarts at every handshake step
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      tmo_r <= 32'h0;
    end else if (load || take || abort || (seq_r != HBP_SEND && seq_r != HBP_WAIT_ARG)) begin
      tmo_r <= 32'h0;
    end else begin
      tmo_r <= tmo_r + 32'h1;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      O_ABORT    <= 1'b0;
      O_BUS_ADDR <= `HBP_ZERO_BYTE;
    end else begin
      O_ABORT    <= abort;
      O_BUS_ADDR <= addr_r;
    end
  end
endmodule // hbp_top
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "hbp_defines.svh"
module tb_top;
  localparam int ABORT = 50;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [23:0] meas = 24'h3C96A5;
  logic [7:0]  ba = `HBP_ADDR_DEFAULT;
  wire  [9:0]  sa;
  wire         ior_n;
  wire         iow_n;
  wire  [7:0]  sd_in;
  wire  [7:0]  sd_out;
  wire         oe;
  wire  [1:0]  chan;
  wire  [7:0]  baddr;
  wire         abort;
  int          fails = 0;
  int          checked = 0;
  int          cyc_n = 0;
  always #25 clk = ~clk;
  hbp_top #(.ABORT_CYCLES(ABORT)) dut (.I_REF_CLK(clk), .I_SRST(srst), .I_SA(sa), .I_IOR_N(ior_n),
    .I_IOW_N(iow_n), .I_SD(sd_in), .O_SD(sd_out), .O_SD_OE(oe), .I_MEAS_VALUE(meas), .O_MEAS_CHAN(chan),
    .O_BUS_ADDR(baddr), .O_ABORT(abort));
  // undriven bus floats high through pull-ups
  hbp_host host (.i_clk(clk), .i_sd(oe ? sd_out : 8'hFF), .o_sa(sa), .o_ior_n(ior_n), .o_iow_n(iow_n),
    .o_sd(sd_in));
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("counts: checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic replies(input int first, input logic [7:0] fl);
    logic [7:0] q;
    for (int i = first; i < 4; i++) begin
      host.poll(ba, 1, 1'b1, q);
      check("flags", q, fl);
      host.cyc({ba, 2'b00}, 1'b1, 8'h00, q);
      check("reply byte", q, i < 3 ? meas[8*i +: 8] : `HBP_SUCCESS_TERM);
    end
  endtask
  task automatic t_fetch(input logic [1:0] ch);
    logic [7:0] q;
    host.poll(ba, 0, 1'b0, q);
    check("write flag idle", q, 8'h00);
    host.cyc({ba, 2'b00}, 1'b0, `HBP_FETCH_CMD | {6'h00, ch}, q);
    replies(0, 8'h02);
    check("channel", {6'h00, chan}, {6'h00, ch});
    host.cyc({ba, 2'b01}, 1'b1, 8'h00, q);
    check("flags after reply", q, 8'h00);
    $display("test fetch %0d done", ch);
  endtask
  // two writes while the sequencer is busy replying; the second must win
  task automatic t_over;
    logic [7:0] q;
    host.cyc({ba, 2'b00}, 1'b0, `HBP_FETCH_CMD, q);
    host.cyc({ba, 2'b00}, 1'b0, `HBP_SET_ADDR_CMD, q);
    host.cyc({ba, 2'b00}, 1'b0, `HBP_FETCH_CMD | 8'h01, q);
    host.cyc({ba, 2'b00}, 1'b1, 8'h00, q);
    check("reply under write", q, meas[7:0]);
    replies(1, 8'h03);
    replies(0, 8'h02);
    check("overwritten channel", {6'h00, chan}, 8'h01);
    $display("test overwrite done");
  endtask
  task automatic t_ignore;
    logic [7:0] q;
    host.cyc({ba ^ 8'h01, 2'b00}, 1'b0, `HBP_FETCH_CMD, q);
    host.cyc({ba, 2'b01}, 1'b0, `HBP_FETCH_CMD | 8'h03, q);
    host.cyc({ba ^ 8'h01, 2'b00}, 1'b1, 8'h00, q);
    check("foreign read", q, 8'hFF);
    host.cyc({ba, 2'b00}, 1'b0, 8'h55, q);
    host.cyc({ba, 2'b01}, 1'b1, 8'h00, q);
    check("flags after ignored", q, 8'h00);
    $display("test ignore done");
  endtask
  task automatic t_abort;
    logic [7:0] q;
    int         n;
    host.cyc({ba, 2'b00}, 1'b0, `HBP_FETCH_CMD | 8'h02, q);
    for (n = 0; n < ABORT + 100 && abort !== 1'b1; n++) @(negedge clk);
    check("abort seen", {7'h00, abort}, 8'h01);
    check("abort waited", {7'h00, n >= ABORT - 10}, 8'h01);
    host.cyc({ba, 2'b01}, 1'b1, 8'h00, q);
    check("flags after abort", q, 8'h00);
    $display("test abort done");
  endtask
  task automatic t_addr;
    logic [7:0] q;
    host.cyc({ba, 2'b00}, 1'b0, `HBP_SET_ADDR_CMD, q);
    host.poll(ba, 0, 1'b0, q);
    host.cyc({ba, 2'b00}, 1'b0, 8'h80, q);
    ba = 8'h80;
    check("new address", baddr, 8'h80);
    host.poll(ba, 1, 1'b1, q);
    host.cyc({ba, 2'b00}, 1'b1, 8'h00, q);
    check("set address end", q, `HBP_SUCCESS_TERM);
    host.cyc({`HBP_ADDR_DEFAULT, 2'b01}, 1'b1, 8'h00, q);
    check("old address dead", q, 8'hFF);
    $display("test address done");
  endtask
  initial begin
    repeat (3) @(negedge clk);
    srst = 1'b0;
    repeat (8) @(negedge clk);
    check("boot address", baddr, `HBP_ADDR_DEFAULT);
    for (int c = 0; c < 4; c++) t_fetch(2'(c));
    t_over();
    t_ignore();
    t_abort();
    t_addr();
    srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    repeat (8) @(negedge clk);
    check("address kept over reset", baddr, 8'h80);
    t_fetch(2'h3);
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
